/* rtl/cfm_bank_layout.sv */
// decodes one filter bank's scale and mode bits into a per-byte layout
// assumes the caller holds the bank's configuration registers
`timescale 1ns/10ps
module cfm_bank_layout (
    input  wire logic [1:0]          scale_in,     // filter_scale_sel
    input  wire logic                low_mode_in,  // low_half_mode_sel
    input  wire logic                high_mode_in, // high_half_mode_sel
    output cfm_pkg::cfm_layout_s     layout_out    // per-byte role
);
    import cfm_pkg::*;

    // ----------------
    // byte roles per scale
    // ----------------
    always_comb begin
        layout_out = '0;
        unique case (cfm_scale_e'(scale_in))
            CFM_SCALE_32: begin
                // bytes 0-3 id, 4-7 mask or second id; 4-5 follow the low mode bit, 6-7 the high mode bit
                layout_out.is_ident = 8'h0f;
                layout_out.is_list  = {{2{high_mode_in}}, {2{low_mode_in}}, 4'h0};
            end
            CFM_SCALE_16X2: begin
                // 0-1 and 4-5 ids, 2-3 and 6-7 partners
                layout_out.is_ident = 8'h33;
                layout_out.is_list  = {{2{high_mode_in}}, 2'h0, {2{low_mode_in}}, 2'h0};
            end
            CFM_SCALE_MIX: begin
                // 16-bit id 0-1 with 2-3; then 4/5 and 6/7 8-bit pairs
                layout_out.is_ident = 8'h53;
                layout_out.is_list  = {high_mode_in, 1'b0, high_mode_in, 1'b0,
                                       {2{low_mode_in}}, 2'h0};
            end
            CFM_SCALE_8X4: begin
                // even bytes ids, odd bytes partners
                layout_out.is_ident = 8'h55;
                layout_out.is_list  = {high_mode_in, 1'b0, high_mode_in, 1'b0,
                                       low_mode_in, 1'b0, low_mode_in, 1'b0};
            end
        endcase
    end

endmodule // cfm_bank_layout

/* rtl/cfm_pkg.sv */
// package for the filter configuration and master status block
// assumes a 20 MHz single clock and an ahb-lite register slave
package cfm_pkg;

    // ----------------
    // register map (byte addresses, one word each)
    // ----------------
    localparam logic [11:0] OFS_MASTER_STATUS  = 12'h000;  // can_master_status
    localparam logic [11:0] OFS_MASTER_CONTROL = 12'h004;  // sleep request
    localparam logic [11:0] OFS_INT_ENABLE     = 12'h008;  // wakeup/error int enables
    localparam logic [11:0] OFS_ERR_STATUS     = 12'h00c;  // error status bits
    localparam logic [11:0] OFS_ERR_INT_ENABLE = 12'h010;  // error status enables
    localparam logic [11:0] OFS_FILTER_MODE    = 12'h014;  // low/high half mode per bank
    localparam logic [11:0] OFS_IRQ_STATUS     = 12'h018;  // sticky event bits
    localparam logic [11:0] OFS_IRQ_MASK       = 12'h01c;  // event mask
    localparam logic [11:0] OFS_FILTER_CTRL    = 12'h040;  // bank control, +4 per bank
    localparam logic [11:0] OFS_FILTER_BYTES   = 12'h080;  // bank bytes, +8 per bank (two words)

    // ----------------
    // field positions and reset values
    // ----------------
    localparam int          MS_RECEIVER   = 5;
    localparam int          MS_TRANSMIT   = 4;
    localparam int          MS_WAKEUP     = 3;
    localparam int          MS_ERROR      = 2;
    localparam int          MS_SLEEP_ACK  = 1;
    localparam int          MS_INIT_ACK   = 0;
    localparam logic [7:0]  MS_RESET      = 8'h02;
    localparam int          FC_ACTIVE     = 0;   // bank_active
    localparam int          FC_SCALE_LSB  = 1;   // filter_scale_sel[1:0]
    localparam int          IE_WAKEUP     = 0;
    localparam int          IE_ERROR      = 1;
    localparam int          EV_STATUS_CHG = 0;   // irq status bit
    localparam int          EV_BUS_ERR    = 1;
    localparam int          ERR_BITS      = 8;

    // ----------------
    // types
    // ----------------
    typedef enum logic [1:0] {
        CFM_SCALE_8X4  = 2'h0,  // four 8-bit filters
        CFM_SCALE_MIX  = 2'h1,  // one 16-bit plus two 8-bit
        CFM_SCALE_16X2 = 2'h2,  // two 16-bit filters
        CFM_SCALE_32   = 2'h3   // one 32-bit filter
    } cfm_scale_e;

    typedef enum logic [2:0] {
        CFM_AWAKE    = 3'b001,
        CFM_ENTERING = 3'b010,
        CFM_ASLEEP   = 3'b100
    } cfm_sleep_e;

    // bus activity coming from the protocol engine
    typedef struct packed {
        logic               receiving;
        logic               transmitting;
        logic               sof_seen;
        logic               bus_idle;
        logic [ERR_BITS-1:0] err_detect;
    } cfm_link_s;

    // per-filter view of one bank: 8 bytes, each tagged id or partner
    typedef struct packed {
        logic [7:0] is_ident;   // byte is an identifier
        logic [7:0] is_list;    // partner byte in list mode (1) or mask mode (0)
    } cfm_layout_s;

endpackage : cfm_pkg

/* rtl/cfm_top.sv */
// filter bank configuration and master status of the can controller
// assumes an ahb-lite master on SYS_CLK_IN and a protocol engine on the same clock
//
// Behaviour
// - scale field picks 32, 16x2, mixed, 8x4
// - low/high mode bits set list or mask
// - 32-bit bytes 0-3 id, 4-7 partner
// - 16-bit pairs: 0-1/2-3 and 4-5/6-7
// - 8-bit: even ids, odd partners
// - master status resets to 02h
// - clearable flags clear on write one
// - top two status bits read zero
// - bits 5/4 show receiver and transmitter
// - wakeup flag on start-of-frame while asleep
// - error flag on enabled error status
// - sleep acknowledge follows sleep entry/exit
//
// The implementer's own choices: the AHB-Lite register port and the register addresses.
`timescale 1ns/10ps
module cfm_top #(
    parameter int BANKS = 4   // number of filter banks
) (
    input  wire logic                  SYS_CLK_IN,     // 20 MHz clock
    input  wire logic                  RST_B_IN,       // sync reset, low
    input  wire logic                  HSEL_IN,        // slave select
    input  wire logic [11:0]           HADDR_IN,       // byte address
    input  wire logic [1:0]            HTRANS_IN,      // transfer type
    input  wire logic                  HWRITE_IN,      // write
    input  wire logic [2:0]            HSIZE_IN,       // size
    input  wire logic                  HREADY_IN,      // bus ready
    input  wire logic [31:0]           HWDATA_IN,      // write data
    output logic      [31:0]           HRDATA_OUT,     // read data
    output logic                       HREADYOUT_OUT,  // always ready
    output logic                       HRESP_OUT,      // always okay
    input  wire cfm_pkg::cfm_link_s    LINK_IN,        // protocol engine state
    output logic                       IRQ_OUT,        // level interrupt
    output logic                       SLEEP_MODE_OUT, // controller asleep
    output logic [BANKS-1:0]           BANK_ACTIVE_OUT, // active banks
    output logic [BANKS*16-1:0]        BANK_LAYOUT_OUT  // layout per bank
);
    import cfm_pkg::*;

    // elaboration check: mode register holds two bits per bank, eight banks at most
    if (BANKS < 1 || BANKS > 8) begin : g_bad_banks
        $error("BANKS must be 1 to 8");
    end

    // -----------------------------------------------------------------
    // declarations
    // -----------------------------------------------------------------
    logic              wr_pend_reg;        // write data phase pending
    logic [11:0]       wr_addr_reg;        // latched write address
    logic [7:0]        ms_flags_reg;       // wakeup and error flags
    logic              sleep_req_reg;      // sleep request from software
    logic [1:0]        int_en_reg;         // wakeup/error int enables
    logic [ERR_BITS-1:0] err_stat_reg;     // error status bits
    logic [ERR_BITS-1:0] err_en_reg;       // error int enables
    logic [15:0]       fmode_reg;          // low/high mode per bank
    logic [1:0]        irq_stat_reg;       // sticky events
    logic [1:0]        irq_mask_reg;       // event mask
    logic [2:0]        fctrl_reg [BANKS];  // active + scale per bank
    logic [63:0]       fbyte_reg [BANKS];  // filter_bank_byte 0..7 per bank
    cfm_sleep_e        sleep_reg;          // sleep state
    cfm_sleep_e        sleep_next;
    logic [31:0]       rdata_next;         // read mux
    logic              addr_ok;            // address phase accepted
    logic              wr_ms, wr_ctl, wr_ie, wr_es, wr_ee, wr_fm, wr_is, wr_im;
    logic              sleep_ack;          // sleep_acknowledge
    logic              wake_evt;           // sof while asleep
    logic [ERR_BITS-1:0] err_new;          // newly set error bits
    logic              err_evt;            // enabled error event
    logic [7:0]        ms_view;            // can_master_status readout
    logic [1:0]        irq_evt;            // events into irq status

    // -----------------------------------------------------------------
    // decode helper
    // -----------------------------------------------------------------
    function automatic logic hit(input logic [11:0] a, input logic [11:0] ofs);
        hit = (a[11:2] == ofs[11:2]);
    endfunction

    // -----------------------------------------------------------------
    // ahb-lite slave: zero wait state, okay always
    // -----------------------------------------------------------------
    assign addr_ok       = HSEL_IN && HREADY_IN && HTRANS_IN[1];
    assign HREADYOUT_OUT = 1'b1;
    assign HRESP_OUT     = 1'b0;

    // latch write address phase
    always_ff @(posedge SYS_CLK_IN) begin
        if (!RST_B_IN) begin
            wr_pend_reg <= 1'b0;
            wr_addr_reg <= 12'h000;
        end else begin
            wr_pend_reg <= addr_ok && HWRITE_IN;
            if (addr_ok) wr_addr_reg <= HADDR_IN;
        end
    end

    // write strobes in the data phase
    assign wr_ms = wr_pend_reg && hit(wr_addr_reg, OFS_MASTER_STATUS);
    assign wr_ctl = wr_pend_reg && hit(wr_addr_reg, OFS_MASTER_CONTROL);
    assign wr_ie = wr_pend_reg && hit(wr_addr_reg, OFS_INT_ENABLE);
    assign wr_es = wr_pend_reg && hit(wr_addr_reg, OFS_ERR_STATUS);
    assign wr_ee = wr_pend_reg && hit(wr_addr_reg, OFS_ERR_INT_ENABLE);
    assign wr_fm = wr_pend_reg && hit(wr_addr_reg, OFS_FILTER_MODE);
    assign wr_is = wr_pend_reg && hit(wr_addr_reg, OFS_IRQ_STATUS);
    assign wr_im = wr_pend_reg && hit(wr_addr_reg, OFS_IRQ_MASK);

    // -----------------------------------------------------------------
    // plain control registers
    // -----------------------------------------------------------------
    always_ff @(posedge SYS_CLK_IN) begin
        if (!RST_B_IN) begin
            sleep_req_reg <= 1'b0;
            int_en_reg    <= 2'h0;
            err_en_reg    <= '0;
            fmode_reg     <= 16'h0000;
            irq_mask_reg  <= 2'h0;
        end else begin
            if (wr_ctl) sleep_req_reg <= HWDATA_IN[0];
            if (wr_ie)  int_en_reg    <= HWDATA_IN[1:0];
            if (wr_ee)  err_en_reg    <= HWDATA_IN[ERR_BITS-1:0];
            if (wr_fm)  fmode_reg     <= HWDATA_IN[15:0];
            if (wr_im)  irq_mask_reg  <= HWDATA_IN[1:0];
        end
    end

    // -----------------------------------------------------------------
    // filter banks: control and byte storage
    // -----------------------------------------------------------------
    genvar b;
    generate
        for (b = 0; b < BANKS; b++) begin : g_bank
            logic wr_fc, wr_lo, wr_hi;
            assign wr_fc = wr_pend_reg && hit(wr_addr_reg, OFS_FILTER_CTRL + 12'(4*b));
            assign wr_lo = wr_pend_reg && hit(wr_addr_reg, OFS_FILTER_BYTES + 12'(8*b));
            assign wr_hi = wr_pend_reg && hit(wr_addr_reg, OFS_FILTER_BYTES + 12'(8*b+4));

            // control: scale only changes while the bank is inactive
            always_ff @(posedge SYS_CLK_IN) begin
                if (!RST_B_IN) begin
                    fctrl_reg[b] <= 3'h0;
                end else if (wr_fc) begin
                    fctrl_reg[b][FC_ACTIVE] <= HWDATA_IN[FC_ACTIVE];
                    if (!fctrl_reg[b][FC_ACTIVE]) begin
                        fctrl_reg[b][FC_SCALE_LSB+:2] <= HWDATA_IN[FC_SCALE_LSB+:2];
                    end
                end
            end

            // bytes 0-3 in low word, 4-7 in high word; byte 0 in bits 7:0
            always_ff @(posedge SYS_CLK_IN) begin
                if (!RST_B_IN) begin
                    fbyte_reg[b] <= 64'h0;
                end else begin
                    if (wr_lo) fbyte_reg[b][31:0]  <= HWDATA_IN;
                    if (wr_hi) fbyte_reg[b][63:32] <= HWDATA_IN;
                end
            end

            // layout decoder for this bank
            cfm_bank_layout u_layout (
                .scale_in     (fctrl_reg[b][FC_SCALE_LSB+:2]),
                .low_mode_in  (fmode_reg[2*b]),
                .high_mode_in (fmode_reg[2*b+1]),
                .layout_out   (BANK_LAYOUT_OUT[16*b+:16])
            );
            assign BANK_ACTIVE_OUT[b] = fctrl_reg[b][FC_ACTIVE];
        end
    endgenerate

    // -----------------------------------------------------------------
    // sleep state machine
    // -----------------------------------------------------------------
    always_comb begin
        sleep_next = sleep_reg;
        unique case (sleep_reg)
            CFM_AWAKE:    if (sleep_req_reg) sleep_next = CFM_ENTERING;
            CFM_ENTERING: if (!sleep_req_reg) sleep_next = CFM_AWAKE;
                          else if (LINK_IN.bus_idle) sleep_next = CFM_ASLEEP;
            CFM_ASLEEP:   if (!sleep_req_reg) sleep_next = CFM_AWAKE;
            default:      sleep_next = CFM_AWAKE;
        endcase
    end

    // sleep state register, reset into sleep so acknowledge reads one
    always_ff @(posedge SYS_CLK_IN) begin
        if (!RST_B_IN) sleep_reg <= CFM_ASLEEP;
        else           sleep_reg <= sleep_next;
    end

    assign sleep_ack      = (sleep_reg == CFM_ASLEEP);
    assign SLEEP_MODE_OUT = sleep_ack;

    // -----------------------------------------------------------------
    // error status and master status flags
    // -----------------------------------------------------------------
    assign err_new  = LINK_IN.err_detect & ~err_stat_reg;
    assign err_evt  = |(err_new & err_en_reg);
    assign wake_evt = LINK_IN.sof_seen && sleep_ack;

    // error status: set by detection, write one to clear, set wins
    always_ff @(posedge SYS_CLK_IN) begin
        if (!RST_B_IN) err_stat_reg <= '0;
        else err_stat_reg <= (err_stat_reg & ~(wr_es ? HWDATA_IN[ERR_BITS-1:0] : '0))
                             | LINK_IN.err_detect;
    end

    // wakeup and error flags, write one clears, set wins over clear
    always_ff @(posedge SYS_CLK_IN) begin
        if (!RST_B_IN) begin
            ms_flags_reg <= 8'h00;
        end else begin
            ms_flags_reg[MS_WAKEUP] <= wake_evt ||
                (ms_flags_reg[MS_WAKEUP] && !(wr_ms && HWDATA_IN[MS_WAKEUP]));
            ms_flags_reg[MS_ERROR]  <= err_evt ||
                (ms_flags_reg[MS_ERROR] && !(wr_ms && HWDATA_IN[MS_ERROR]));
        end
    end

    // readout: top bits zero, live receiver/transmitter
    always_comb begin
        ms_view               = 8'h00;
        ms_view[MS_RECEIVER]  = LINK_IN.receiving;
        ms_view[MS_TRANSMIT]  = LINK_IN.transmitting;
        ms_view[MS_WAKEUP]    = ms_flags_reg[MS_WAKEUP];
        ms_view[MS_ERROR]     = ms_flags_reg[MS_ERROR];
        ms_view[MS_SLEEP_ACK] = sleep_ack;
        ms_view[MS_INIT_ACK]  = 1'b0;
    end

    // -----------------------------------------------------------------
    // interrupt: status change from enabled flags, plus any error detection
    // -----------------------------------------------------------------
    assign irq_evt[EV_STATUS_CHG] = (wake_evt && int_en_reg[IE_WAKEUP])
                                 || (err_evt && int_en_reg[IE_ERROR]);
    assign irq_evt[EV_BUS_ERR]    = |LINK_IN.err_detect;

    // sticky, write one to clear, set wins
    always_ff @(posedge SYS_CLK_IN) begin
        if (!RST_B_IN) irq_stat_reg <= 2'h0;
        else irq_stat_reg <= (irq_stat_reg & ~(wr_is ? HWDATA_IN[1:0] : 2'h0)) | irq_evt;
    end

    assign IRQ_OUT = |(irq_stat_reg & irq_mask_reg);

    // -----------------------------------------------------------------
    // read data, registered in the data phase
    // -----------------------------------------------------------------
    always_comb begin
        rdata_next = 32'h0000_0000;
        if (hit(HADDR_IN, OFS_MASTER_STATUS))       rdata_next[7:0] = ms_view;
        else if (hit(HADDR_IN, OFS_MASTER_CONTROL)) rdata_next[0] = sleep_req_reg;
        else if (hit(HADDR_IN, OFS_INT_ENABLE))     rdata_next[1:0] = int_en_reg;
        else if (hit(HADDR_IN, OFS_ERR_STATUS))     rdata_next[ERR_BITS-1:0] = err_stat_reg;
        else if (hit(HADDR_IN, OFS_ERR_INT_ENABLE)) rdata_next[ERR_BITS-1:0] = err_en_reg;
        else if (hit(HADDR_IN, OFS_FILTER_MODE))    rdata_next[15:0] = fmode_reg;
        else if (hit(HADDR_IN, OFS_IRQ_STATUS))     rdata_next[1:0] = irq_stat_reg;
        else if (hit(HADDR_IN, OFS_IRQ_MASK))       rdata_next[1:0] = irq_mask_reg;
        else begin
            for (int i = 0; i < BANKS; i++) begin
                if (hit(HADDR_IN, OFS_FILTER_CTRL + 12'(4*i)))    rdata_next[2:0] = fctrl_reg[i];
                if (hit(HADDR_IN, OFS_FILTER_BYTES + 12'(8*i)))   rdata_next = fbyte_reg[i][31:0];
                if (hit(HADDR_IN, OFS_FILTER_BYTES + 12'(8*i+4))) rdata_next = fbyte_reg[i][63:32];
            end
        end
    end

    // capture read data at the end of the address phase
    always_ff @(posedge SYS_CLK_IN) begin
        if (!RST_B_IN)                   HRDATA_OUT <= 32'h0000_0000;
        else if (addr_ok && !HWRITE_IN)  HRDATA_OUT <= rdata_next;
    end

endmodule // cfm_top

/* verif/cfm_can_node_model.sv */
// model of the other nodes and engine activity seen by the block
// assumes the bench picks an activity mode on the system clock
`timescale 1ns/10ps
module cfm_can_node_model (
    input  wire logic      clk_in,   // system clock
    input  wire logic [2:0] mode_in, // 0 idle, 1 rx, 2 tx, 3 sof, 4 error
    output cfm_pkg::cfm_link_s link_out
);
    import cfm_pkg::*;
    // quiet bus until the first edge
    initial link_out = '0;
    // one registered update per cycle, pulses last as long as the mode is held
    always @(posedge clk_in) begin
        link_out.receiving    <= (mode_in == 3'h1);
        link_out.transmitting <= (mode_in == 3'h2);
        link_out.bus_idle     <= (mode_in == 3'h0);
        link_out.sof_seen     <= (mode_in == 3'h3);
        link_out.err_detect   <= (mode_in == 3'h4) ? (8'h01 << $urandom_range(7)) : 8'h00;
    end
endmodule // cfm_can_node_model

/* verif/cfm_top_assertions.sv */
// checker: bus, interrupt, sleep and layout relations at the top ports
// assumes cfm_top on one clock with a synchronous active-low reset
`timescale 1ns/10ps
module cfm_top_checker
    import cfm_pkg::*;
#(
    parameter int BANKS = 4  // filter banks
) (
    input wire logic                 SYS_CLK_IN,
    input wire logic                 RST_B_IN,
    input wire logic                 HSEL_IN,
    input wire logic [1:0]           HTRANS_IN,
    input wire logic                 HWRITE_IN,
    input wire logic                 HREADY_IN,
    input wire logic [31:0]          HRDATA_OUT,
    input wire logic                 HREADYOUT_OUT,
    input wire logic                 HRESP_OUT,
    input wire cfm_link_s            LINK_IN,
    input wire logic                 IRQ_OUT,
    input wire logic                 SLEEP_MODE_OUT,
    input wire logic [BANKS-1:0]     BANK_ACTIVE_OUT,
    input wire logic [BANKS*16-1:0]  BANK_LAYOUT_OUT
);
    // ----------------
    // helpers
    // ----------------
    default clocking cb @(posedge SYS_CLK_IN); endclocking
    default disable iff (!RST_B_IN);
    logic wr_dp;  // write data phase in progress
    logic rd_dp;  // read data phase in progress
    logic take;   // address phase accepted
    assign take = HSEL_IN && HREADY_IN && HTRANS_IN[1];
    // data phase trackers, cleared in reset
    always_ff @(posedge SYS_CLK_IN) begin
        wr_dp <= RST_B_IN && take && HWRITE_IN;
        rd_dp <= RST_B_IN && take && !HWRITE_IN;
    end
    // ----------------
    // assertions
    // ----------------
    a_ready_always: assert property (HREADYOUT_OUT == 1'b1) else $error("slave inserted a wait");
    a_resp_okay: assert property (HRESP_OUT == 1'b0) else $error("slave gave non-okay response");
    a_rdata_holds: assert property (!rd_dp |-> $stable(HRDATA_OUT)) else $error("read data moved");
    a_sleep_on_idle: assert property ($rose(SLEEP_MODE_OUT) |-> $past(LINK_IN.bus_idle))
        else $error("sleep entered on busy bus");
    a_irq_rise_cause: assert property ($rose(IRQ_OUT) |-> $past(wr_dp) || $past(LINK_IN.sof_seen)
        || $past(LINK_IN.sof_seen, 2) || $past(|LINK_IN.err_detect) || $past(|LINK_IN.err_detect, 2))
        else $error("interrupt rose with no cause");
    a_irq_fall_write: assert property ($fell(IRQ_OUT) |-> $past(wr_dp)) else $error("irq fell alone");
    a_active_by_write: assert property ($changed(BANK_ACTIVE_OUT) |-> $past(wr_dp))
        else $error("bank active moved without a write");
    a_layout_by_write: assert property ($changed(BANK_LAYOUT_OUT) |-> $past(wr_dp))
        else $error("layout moved without a write");
    a_layout_frozen: assert property (BANK_ACTIVE_OUT[0] && $past(BANK_ACTIVE_OUT[0])
        |-> $stable(BANK_LAYOUT_OUT[15:8])) else $error("scale changed on active bank");
    a_ident_legal: assert property (BANK_LAYOUT_OUT[15:8] inside {8'h55, 8'h53, 8'h33, 8'h0f})
        else $error("illegal identifier layout");
    a_list_partner: assert property ((BANK_LAYOUT_OUT[15:8] & BANK_LAYOUT_OUT[7:0]) == 8'h00)
        else $error("list mode on identifier byte");
    c_irq_rise: cover property ($rose(IRQ_OUT));
    c_sleep_in: cover property ($rose(SLEEP_MODE_OUT));
    c_read: cover property (rd_dp);
endmodule // cfm_top_checker

bind cfm_top cfm_top_checker #(.BANKS(BANKS)) u_cfm_top_checker (
    .SYS_CLK_IN, .RST_B_IN, .HSEL_IN, .HTRANS_IN, .HWRITE_IN, .HREADY_IN, .HRDATA_OUT, .HREADYOUT_OUT,
    .HRESP_OUT, .LINK_IN, .IRQ_OUT, .SLEEP_MODE_OUT, .BANK_ACTIVE_OUT, .BANK_LAYOUT_OUT);

/* verif/tb_top.sv */
// self-checking bench for the filter and master status block
// assumes zero-wait ahb-lite slave, bank 0 used for layout checks
`timescale 1ns/10ps
module tb_top;
    import cfm_pkg::*;
    // ----------------
    // signals and instances
    // ----------------
    logic        clk = 1'b0, rst_b = 1'b0, hsel = 1'b0, hwrite = 1'b0, dp_rd = 1'b0, l, h;
    logic [11:0] haddr = 12'h000;
    logic [1:0]  htrans = 2'h0;
    logic [2:0]  hsize = 3'h2, mode = 3'h0;
    logic [31:0] hwdata = 32'h0, hrdata, w0, w1;
    logic        hready, hreadyout, hresp, irq, sleep;
    logic [3:0]  act;
    logic [63:0] lay;
    cfm_link_s   link;
    int          fails = 0, cmp_count = 0;
    logic [31:0] exp_q[$];  // expected read data, oldest first
    localparam logic [7:0] ID_T [4] = '{8'h55, 8'h53, 8'h33, 8'h0f};
    localparam logic [7:0] LO_T [4] = '{8'h0a, 8'h0c, 8'h0c, 8'h30};
    localparam logic [7:0] HI_T [4] = '{8'ha0, 8'ha0, 8'hc0, 8'hc0};
    assign hready = hreadyout;  // single slave drives bus ready
    always #25 clk = ~clk;
    cfm_top #(.BANKS(4)) u_cfm_top (.SYS_CLK_IN(clk), .RST_B_IN(rst_b), .HSEL_IN(hsel), .HADDR_IN(haddr),
        .HTRANS_IN(htrans), .HWRITE_IN(hwrite), .HSIZE_IN(hsize), .HREADY_IN(hready), .HWDATA_IN(hwdata),
        .HRDATA_OUT(hrdata), .HREADYOUT_OUT(hreadyout), .HRESP_OUT(hresp), .LINK_IN(link), .IRQ_OUT(irq),
        .SLEEP_MODE_OUT(sleep), .BANK_ACTIVE_OUT(act), .BANK_LAYOUT_OUT(lay));
    cfm_can_node_model u_cfm_can_node_model (.clk_in(clk), .mode_in(mode), .link_out(link));
    // ----------------
    // tasks
    // ----------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            fails++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic close_out;
        $display("counts: compares=%0d mismatches=%0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    // bounded wait for bus ready at a rising edge
    task automatic wait_rdy;
        int n;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (hready !== 1'b1 && n < 50);
        if (hready !== 1'b1) begin
            fails++;
            close_out();
        end
    endtask
    // one single-word transfer: address phase, then data phase
    task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= a;
        hwrite <= w;
        wait_rdy();
        htrans <= 2'h0;
        hwdata <= d;
        dp_rd <= !w;
        wait_rdy();
        dp_rd <= 1'b0;
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] e);
        exp_q.push_back(e);
        bus(1'b0, a, 32'h0);
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        bus(1'b1, a, d);
    endtask
    task automatic pulse(input logic [2:0] m);
        mode <= m;
        @(posedge clk);
        mode <= 3'h0;
        repeat (2) @(posedge clk);
    endtask
    task automatic irq_is(input logic e);
        @(negedge clk);
        chk({31'h0, irq}, {31'h0, e});
    endtask
    // read data taken at the edge that ends the data phase
    always @(posedge clk) begin
        if (dp_rd && hready === 1'b1) chk(hrdata, exp_q.pop_front());
    end
    // ----------------
    // main sequence
    // ----------------
    initial begin
        void'($urandom(32'hbc54));
        repeat (20) @(posedge clk);
        chk({31'h0, sleep}, 32'h1);
        rst_b <= 1'b1;
        repeat (3) @(posedge clk);
        rd(OFS_MASTER_STATUS, 32'h00);
        wr(OFS_MASTER_STATUS, 32'hff);
        rd(OFS_MASTER_STATUS, 32'h00);
        for (int i = 1; i < 3; i++) begin
            mode <= 3'(i);
            repeat (2) @(posedge clk);
            rd(OFS_MASTER_STATUS, (i == 1) ? 32'h20 : 32'h10);
        end
        mode <= 3'h0;
        $display("test link status done");
        wr(OFS_INT_ENABLE, 32'h3);
        wr(OFS_IRQ_MASK, 32'h1);
        wr(OFS_MASTER_CONTROL, 32'h1);
        repeat (2) @(posedge clk);
        rd(OFS_MASTER_STATUS, 32'h02);
        pulse(3'h3);
        rd(OFS_MASTER_STATUS, 32'h0a);
        irq_is(1'b1);
        wr(OFS_MASTER_STATUS, 32'h0);
        rd(OFS_MASTER_STATUS, 32'h0a);
        wr(OFS_MASTER_STATUS, 32'h08);
        rd(OFS_MASTER_STATUS, 32'h02);
        wr(OFS_IRQ_MASK, 32'h0);
        irq_is(1'b0);
        wr(OFS_IRQ_MASK, 32'h1);
        irq_is(1'b1);
        wr(OFS_IRQ_STATUS, 32'h3);
        wr(OFS_IRQ_MASK, 32'h3);
        irq_is(1'b0);
        wr(OFS_MASTER_CONTROL, 32'h0);
        rd(OFS_MASTER_STATUS, 32'h00);
        $display("test sleep and wakeup done");
        pulse(3'h4);
        rd(OFS_MASTER_STATUS, 32'h00);
        irq_is(1'b1);
        wr(OFS_IRQ_MASK, 32'h1);
        wr(OFS_ERR_STATUS, 32'hff);
        wr(OFS_ERR_INT_ENABLE, 32'hff);
        pulse(3'h4);
        rd(OFS_MASTER_STATUS, 32'h04);
        irq_is(1'b1);
        wr(OFS_MASTER_STATUS, 32'h04);
        wr(OFS_IRQ_STATUS, 32'h3);
        rd(OFS_MASTER_STATUS, 32'h00);
        irq_is(1'b0);
        $display("test error flag done");
        for (int s = 0; s < 4; s++) begin
            l = 1'($urandom);
            h = (s == 3) ? l : 1'($urandom);
            wr(OFS_FILTER_CTRL, 32'h0);
            wr(OFS_FILTER_MODE, {30'h0, h, l});
            wr(OFS_FILTER_CTRL, {29'h0, s[1:0], 1'b0});
            @(negedge clk);
            chk({16'h0, lay[15:0]}, {16'h0, ID_T[s], (LO_T[s] & {8{l}}) | (HI_T[s] & {8{h}})});
        end
        wr(OFS_FILTER_CTRL, 32'h1);
        wr(OFS_FILTER_CTRL, 32'h7);
        @(negedge clk);
        chk({28'h0, act}, 32'h1);
        chk({24'h0, lay[15:8]}, 32'h55);
        w0 = $urandom;
        w1 = $urandom;
        wr(OFS_FILTER_BYTES + 12'h008, w0);
        wr(OFS_FILTER_BYTES + 12'h00c, w1);
        rd(OFS_FILTER_BYTES + 12'h008, w0);
        rd(OFS_FILTER_BYTES + 12'h00c, w1);
        rd(12'h03c, 32'h0);
        $display("test filter banks done");
        repeat (2) @(posedge clk);
        close_out();
    end
    // hang guard
    initial begin
        repeat (20000) @(posedge clk);
        fails++;
        close_out();
    end
endmodule // tb_top
